// [eitt_pkg.sv]
/*
  Package for the three-channel 8-bit interval timer: register addresses,
  control field positions, reset values, clock-select codes and prescaler taps.
  Assumes an 8-bit internal register port with a 16-bit byte address.
*/
package eitt_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] ADDR_PORT2_DIR  = 16'hff22;
  localparam logic [15:0] ADDR_PORT3_DIR  = 16'hff23;
  localparam logic [15:0] ADDR_CTRL0      = 16'hff53;
  localparam logic [15:0] ADDR_CTRL1      = 16'hff57;
  localparam logic [15:0] ADDR_CTRL2      = 16'hff5b;
  localparam logic [15:0] ADDR_CMP0       = 16'hff60;
  localparam logic [15:0] ADDR_CMP1       = 16'hff61;
  localparam logic [15:0] ADDR_CMP2       = 16'hff62;
  localparam logic [15:0] ADDR_CNT0       = 16'hff64;
  localparam logic [15:0] ADDR_CNT1       = 16'hff65;
  localparam logic [15:0] ADDR_CNT2       = 16'hff66;
  localparam logic [7:0]  DIR_RESET       = 8'hff;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_MASK       = 8'hc7;
  localparam logic [7:0]  PORT2_FIXED_ONE = 8'h80;
  localparam logic [7:0]  PORT3_FIXED_ONE = 8'hf0;
  localparam int          BIT_ENABLE      = 7;
  localparam int          BIT_SEL_HI      = 2;
  localparam int          BIT_SEL_LO      = 1;
  localparam int          PIN2_6          = 6;
  localparam int          PIN3_1          = 1;
  localparam int          PIN3_3          = 3;
  localparam logic [1:0]  SEL_A           = 2'h0;
  localparam logic [1:0]  SEL_B           = 2'h1;
  localparam logic [1:0]  SEL_C           = 2'h2;
  localparam int          PRE_W           = 8;
  // Prescaler taps as log2 of the division ratio
  localparam int          T0_DIV_B        = 3;
  localparam int          T1_DIV_A        = 4;
  localparam int          T1_DIV_B        = 8;
  localparam int          T2_DIV_A        = 5;
  localparam int          T2_DIV_B        = 7;
endpackage

// [eitt_timer_trio.sv]
/*
  Three 8-bit interval timers with compare-clear and match pulses, plus the
  port 2 and port 3 direction registers that enable the timer output pins.
  Assumes a synchronous register port on clock, sub-clock and external count
  inputs synchronous to clock, and port output latches held outside.
*/
module eitt_timer_trio (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [eitt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [eitt_pkg::DATA_W-1:0] reg_wdata,
  output logic      [eitt_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        sub_clk,
  input  wire logic                        t0_ext_count_in,
  input  wire logic                        t1_ext_count_in,
  input  wire logic [2:0]                  timer_out_level,
  output logic      [2:0]                  match_irq,
  output logic      [2:0]                  timer_out_pin,
  output logic      [2:0]                  timer_out_oe,
  output logic      [7:0]                  port2_dir,
  output logic      [7:0]                  port3_dir
);
  import eitt_pkg::*;

  logic [7:0]       port2_direction_reg, port2_direction_next;
  logic [7:0]       port3_direction_reg, port3_direction_next;
  logic [2:0][7:0]  timer_control_reg, timer_control_next;
  logic [2:0][7:0]  compare_value_reg, compare_value_next;
  logic [2:0][7:0]  up_counter_value_reg, up_counter_value_next;
  logic [2:0]       match_reg, match_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [2:0]       ext_reg, ext_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic [2:0]       tick;
  logic [2:0]       ext_rise, ext_fall;

  // One-cycle pulse when the free prescaler wraps at 2**k
  function automatic logic tap(input logic [PRE_W-1:0] p, input int k);
    logic [PRE_W-1:0] m;
    m = PRE_W'((1 << k) - 1);
    return (p & m) == m;
  endfunction

  function automatic logic [1:0] sel_of(input logic [7:0] c);
    return {c[BIT_SEL_HI], c[BIT_SEL_LO]};
  endfunction

  assign ext_rise = ext_next & ~ext_reg;
  assign ext_fall = ~ext_next & ext_reg;

  // Count clock selection per timer
  always_comb begin
    tick = '0;
    unique case (sel_of(timer_control_reg[0]))
      SEL_A:   tick[0] = 1'b1;
      SEL_B:   tick[0] = tap(pre_reg, T0_DIV_B);
      SEL_C:   tick[0] = ext_rise[0];
      default: tick[0] = ext_fall[0];
    endcase
    unique case (sel_of(timer_control_reg[1]))
      SEL_A:   tick[1] = tap(pre_reg, T1_DIV_A);
      SEL_B:   tick[1] = tap(pre_reg, T1_DIV_B);
      SEL_C:   tick[1] = ext_rise[1];
      default: tick[1] = ext_fall[1];
    endcase
    unique case (sel_of(timer_control_reg[2]))
      SEL_A:   tick[2] = tap(pre_reg, T2_DIV_A);
      SEL_B:   tick[2] = tap(pre_reg, T2_DIV_B);
      SEL_C:   tick[2] = ext_rise[2];
      default: tick[2] = 1'b0;                           // Prohibited code idles
    endcase
  end

  always_comb begin
    pre_next              = PRE_W'(pre_reg + 1'b1);
    ext_next              = {sub_clk, t1_ext_count_in, t0_ext_count_in};
    port2_direction_next  = port2_direction_reg;
    port3_direction_next  = port3_direction_reg;
    timer_control_next    = timer_control_reg;
    compare_value_next    = compare_value_reg;
    up_counter_value_next = up_counter_value_reg;
    match_next            = '0;
    for (int i = 0; i < 3; i++) begin
      if (!timer_control_reg[i][BIT_ENABLE]) begin
        up_counter_value_next[i] = 8'h00;
      end else if (tick[i]) begin
        if (up_counter_value_reg[i] == compare_value_reg[i]) begin
          up_counter_value_next[i] = 8'h00;
          match_next[i]            = 1'b1;
        end else begin
          up_counter_value_next[i] = 8'(up_counter_value_reg[i] + 1'b1);
        end
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PORT2_DIR: port2_direction_next  = reg_wdata | PORT2_FIXED_ONE;
        ADDR_PORT3_DIR: port3_direction_next  = reg_wdata | PORT3_FIXED_ONE;
        ADDR_CTRL0:     timer_control_next[0] = reg_wdata & CTRL_MASK;
        ADDR_CTRL1:     timer_control_next[1] = reg_wdata & CTRL_MASK;
        ADDR_CTRL2:     timer_control_next[2] = reg_wdata & CTRL_MASK;
        ADDR_CMP0:      compare_value_next[0] = reg_wdata;
        ADDR_CMP1:      compare_value_next[1] = reg_wdata;
        ADDR_CMP2:      compare_value_next[2] = reg_wdata;
        default:        ;
      endcase
    end
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PORT2_DIR: rdata_next = port2_direction_reg;
        ADDR_PORT3_DIR: rdata_next = port3_direction_reg;
        ADDR_CTRL0:     rdata_next = timer_control_reg[0];
        ADDR_CTRL1:     rdata_next = timer_control_reg[1];
        ADDR_CTRL2:     rdata_next = timer_control_reg[2];
        ADDR_CMP0:      rdata_next = compare_value_reg[0];
        ADDR_CMP1:      rdata_next = compare_value_reg[1];
        ADDR_CMP2:      rdata_next = compare_value_reg[2];
        ADDR_CNT0:      rdata_next = up_counter_value_reg[0];
        ADDR_CNT1:      rdata_next = up_counter_value_reg[1];
        ADDR_CNT2:      rdata_next = up_counter_value_reg[2];
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port2_direction_reg  <= DIR_RESET;
      port3_direction_reg  <= DIR_RESET;
      timer_control_reg    <= {3{CTRL_RESET}};
      compare_value_reg    <= '0;
      up_counter_value_reg <= '0;
      match_reg            <= '0;
      pre_reg              <= '0;
      ext_reg              <= ext_next;                  // Primed so a high idle pin gives no edge
      rdata_reg            <= '0;
    end else begin
      port2_direction_reg  <= port2_direction_next;
      port3_direction_reg  <= port3_direction_next;
      timer_control_reg    <= timer_control_next;
      compare_value_reg    <= compare_value_next;
      up_counter_value_reg <= up_counter_value_next;
      match_reg            <= match_next;
      pre_reg              <= pre_next;
      ext_reg              <= ext_next;
      rdata_reg            <= rdata_next;
    end
  end

  assign match_irq     = match_reg;
  assign reg_rdata     = rdata_reg;
  assign port2_dir     = port2_direction_reg;
  assign port3_dir     = port3_direction_reg;
  assign timer_out_pin = timer_out_level;
  // Output buffer on while the direction bit is 0
  assign timer_out_oe  = {~port3_direction_reg[PIN3_3], ~port3_direction_reg[PIN3_1],
                          ~port2_direction_reg[PIN2_6]};

  property p_match_clears;
    @(posedge clock) disable iff (sys_rst)
      (timer_control_reg[0][BIT_ENABLE] && tick[0] &&
       up_counter_value_reg[0] == compare_value_reg[0] && !reg_wr)
      |=> (up_counter_value_reg[0] == 8'h00 && match_irq[0]);
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("no clear on match");

  property p_match_cause;
    @(posedge clock) disable iff (sys_rst)
      match_irq[1] |-> $past(up_counter_value_reg[1]) == $past(compare_value_reg[1]);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without equality");

  property p_disable_zero;
    @(posedge clock) disable iff (sys_rst)
      !timer_control_reg[2][BIT_ENABLE] |=> up_counter_value_reg[2] == 8'h00;
  endproperty
  a_disable_zero: assert property (p_disable_zero) else $error("disabled counter not zero");

  property p_advance;
    @(posedge clock) disable iff (sys_rst)
      (timer_control_reg[0][BIT_ENABLE] && tick[0] && !reg_wr &&
       up_counter_value_reg[0] != compare_value_reg[0])
      |=> up_counter_value_reg[0] == $past(up_counter_value_reg[0]) + 8'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance");

  property p_hold;
    @(posedge clock) disable iff (sys_rst)
      (timer_control_reg[1][BIT_ENABLE] && !tick[1] && !reg_wr)
      |=> $stable(up_counter_value_reg[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_t0_fast;
    @(posedge clock) disable iff (sys_rst)
      sel_of(timer_control_reg[0]) == SEL_A |-> tick[0];
  endproperty
  a_t0_fast: assert property (p_t0_fast) else $error("timer 0 main clock tick missing");

  property p_t1_div;
    @(posedge clock) disable iff (sys_rst)
      (tick[1] && sel_of(timer_control_reg[1]) == SEL_A) |-> pre_reg[3:0] == 4'hf;
  endproperty
  a_t1_div: assert property (p_t1_div) else $error("timer 1 divide by 16 wrong");

  property p_t2_div;
    @(posedge clock) disable iff (sys_rst)
      (tick[2] && sel_of(timer_control_reg[2]) == SEL_B) |-> pre_reg[6:0] == 7'h7f;
  endproperty
  a_t2_div: assert property (p_t2_div) else $error("timer 2 divide by 128 wrong");

  property p_oe;
    @(posedge clock) disable iff (sys_rst)
      timer_out_oe[0] == !port2_direction_reg[PIN2_6];
  endproperty
  a_oe: assert property (p_oe) else $error("output enable disagrees with direction");

  property p_reset_dir;
    @(posedge clock) $fell(sys_rst) |-> port2_dir == 8'hff && port3_dir == 8'hff;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("direction not ones after reset");
endmodule

// [eitt_timer_trio_tb.sv]
/*
  Self-checking bench for the three-channel interval timer and port direction registers.
  Assumes the design package and the timer top module are compiled first.
*/
module eitt_timer_trio_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eitt_pkg::*;
  logic        clock;
  logic        sys_rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        sub_clk;
  logic        t0_ext_count_in;
  logic        t1_ext_count_in;
  logic [2:0]  timer_out_level;
  logic [2:0]  match_irq;
  logic [2:0]  timer_out_pin;
  logic [2:0]  timer_out_oe;
  logic [7:0]  port2_dir;
  logic [7:0]  port3_dir;
  logic        ext_ph;
  int          failures;
  int          checked;
  // Timer, select code and clock cycles per count tick for each case
  // Timer 2 is given codes 0 to 2 only, never the prohibited code
  int          tmr_tab  [11] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2};
  int          code_tab [11] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 2};
  int          mult_tab [11] = '{1, 8, 4, 4, 16, 256, 4, 4, 32, 128, 4};

  eitt_timer_trio u_dut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sub_clk(sub_clk),
    .t0_ext_count_in(t0_ext_count_in), .t1_ext_count_in(t1_ext_count_in),
    .timer_out_level(timer_out_level), .match_irq(match_irq), .timer_out_pin(timer_out_pin),
    .timer_out_oe(timer_out_oe), .port2_dir(port2_dir), .port3_dir(port3_dir));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // External inputs and sub-clock toggle every 2 cycles: one edge of each kind per 4 cycles
  always @(posedge clock) begin
    ext_ph <= ~ext_ph;
    if (ext_ph) begin
      t0_ext_count_in <= ~t0_ext_count_in;
      t1_ext_count_in <= ~t1_ext_count_in;
      sub_clk         <= ~sub_clk;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask

  // Waits for one match pulse, then counts cycles to the next one
  task automatic interval(input int t, output int n);
    int i;
    n = 0;
    for (i = 0; i < 4000 && match_irq[t] !== 1'b1; i++) @(negedge clock);
    if (i >= 4000) begin
      failures++;
      $display("CHECK FAILED first match expected pulse seen none");
      summarize();
    end
    @(negedge clock);
    chk("pulse width", 16'h0000, {15'h0000, match_irq[t]});
    n = 1;
    while (match_irq[t] !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000) begin
      failures++;
      $display("CHECK FAILED match wait expected pulse seen none");
      summarize();
    end
    @(posedge clock);
  endtask

  initial begin
    int k;
    int t;
    int n;
    logic [15:0] ca;
    {reg_wr, reg_rd, reg_addr, reg_wdata, sub_clk, ext_ph} = '0;
    {t0_ext_count_in, t1_ext_count_in, failures, checked} = '0;
    timer_out_level = 3'h5;
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("port2_dir", 16'h00ff, {8'h00, port2_dir});
    chk("port3_dir", 16'h00ff, {8'h00, port3_dir});
    chk("oe", 16'h0000, {13'h0000, timer_out_oe});
    rd_chk("rd port2", ADDR_PORT2_DIR, DIR_RESET);
    rd_chk("rd port3", ADDR_PORT3_DIR, DIR_RESET);
    rd_chk("rd unmapped", 16'hff30, 8'h00);
    $display("test reset done");
    wr(ADDR_PORT2_DIR, 8'hbf);
    chk("oe p26", 16'h0001, {13'h0000, timer_out_oe});
    wr(ADDR_PORT3_DIR, 8'h00);
    chk("oe all", 16'h0007, {13'h0000, timer_out_oe});
    rd_chk("rd port3 fixed", ADDR_PORT3_DIR, PORT3_FIXED_ONE);
    chk("pin level", 16'h0005, {13'h0000, timer_out_pin});
    wr(ADDR_PORT2_DIR, 8'hff);
    chk("oe p26 off", 16'h0006, {13'h0000, timer_out_oe});
    $display("test direction done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("port3_dir after reset", 16'h00ff, {8'h00, port3_dir});
    chk("oe after reset", 16'h0000, {13'h0000, timer_out_oe});
    $display("test mid reset done");
    for (k = 0; k < 11; k++) begin
      t  = tmr_tab[k];
      ca = ADDR_CTRL0 + 16'(4 * t);
      wr(ca, 8'h00);
      wr(ca, 8'(code_tab[k] << 1));
      wr(ADDR_CMP0 + 16'(t), 8'h02);
      wr(ca, 8'h80 | 8'(code_tab[k] << 1));
      interval(t, n);
      chk("interval", 16'(3 * mult_tab[k]), 16'(n));
      wr(ca, 8'(code_tab[k] << 1));
      rd_chk("stopped count", ADDR_CNT0 + 16'(t), 8'h00);
      repeat (40) @(posedge clock);
      chk("no match stopped", 16'h0000, {13'h0000, match_irq});
    end
    $display("test intervals done");
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CTRL0, 8'h02);
    wr(ADDR_CMP0, 8'h00);
    wr(ADDR_CTRL0, 8'h82);
    interval(0, n);
    chk("interval cmp 00", 16'h0008, 16'(n));
    wr(ADDR_CTRL0, 8'h02);
    wr(ADDR_CMP0, 8'hff);
    wr(ADDR_CTRL0, 8'h82);
    interval(0, n);
    chk("interval cmp ff", 16'h0800, 16'(n));
    wr(ADDR_CTRL0, 8'h00);
    $display("test boundary done");
    summarize();
  end
endmodule
